//--- hw/ovt_target_ctrl.sv
`timescale 1ns/10ps
module ovt_target_ctrl (
  // Clock, clock enable and synchronous reset
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic rst,
  // PMBus pins, open drain
  input wire logic pmb_scl,
  input wire logic pmb_sda_in,
  output logic pmb_sda_out,
  output logic pmb_sda_oe,
  output logic pmb_alert_out,
  output logic pmb_alert_oe,
  // Board pin, low asserts reset when enabled
  input wire logic power_good_or_reset_pin,
  // Default sources and converter state
  input wire logic [15:0] nvm_target,
  input wire logic [15:0] voltage_select_strap_pin,
  input wire logic [7:0] nvm_trim,
  input wire logic conv_en,
  input wire logic fault_shutdown,
  // Reference and backup outputs
  output logic [15:0] dac_code,
  output logic dac_moving,
  output logic [15:0] boot_voltage,
  output logic [7:0] nvm_trim_save
);
  // Widens a word to 2^-12 V units at the active exponent.
  function automatic logic signed [25:0] up(input logic [15:0] v,
    input logic sgn, input logic [3:0] s);
    up = $signed({(sgn ? {10{v[15]}} : 10'h000), v}) <<< s;
  endfunction : up

  logic [2:0] sync_out;
  logic scl_d;
  logic sda_d;
  ovt_pkg::ovt_bus_e st;
  logic [3:0] bitc;
  logic [7:0] sh;
  logic [7:0] tx;
  logic tx_hi;
  logic rw;
  logic [7:0] cmd;
  logic [1:0] nbytes;
  logic [15:0] wdata;
  logic wr_live;
  logic [15:0] output_target_word;
  logic [15:0] output_offset_word;
  logic [15:0] output_ceiling_word;
  logic [15:0] floor_word;
  logic [15:0] rate_word;
  logic [4:0] mode_exp;
  logic [7:0] cfg;
  logic boot_pending;
  logic warn;
  logic cml_data;
  logic cml_cmd;
  logic [15:0] ref_target;

  // Two-flop synchronisers for clock, data and reset pin.
  wire [2:0] raw_in = {power_good_or_reset_pin, pmb_sda_in, pmb_scl};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      logic s1;
      logic s2;
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
        end
        else if (ce)
        begin
          s1 <= raw_in[gi];
          s2 <= s1;
        end
      end
      assign sync_out[gi] = s2;
    end
  endgenerate

  // Bus edge and condition detection on synchronised pins.
  wire scl_s = sync_out[0];
  wire sda_s = sync_out[1];
  wire rpin_s = sync_out[2];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  wire in_frame = st != ovt_pkg::ST_IDLE;
  wire is_tx = st == ovt_pkg::ST_TX;
  wire addr_miss = (st == ovt_pkg::ST_ADDR) & (sh[7:1] != ovt_pkg::DEV_ADDR);

  // Transaction decode at the stop condition.
  wire commit = stop_ev & wr_live;
  wire wr_word = commit & (nbytes == 2'h2);
  wire wr_byte = commit & (nbytes == 2'h1);
  wire wr_send = commit & (nbytes == 2'h0);
  wire w_target = wr_word & (cmd == ovt_pkg::CMD_TARGET);
  wire w_offset = wr_word & (cmd == ovt_pkg::CMD_OFFSET);
  wire w_ceil = wr_word & (cmd == ovt_pkg::CMD_CEIL);
  wire w_floor = wr_word & (cmd == ovt_pkg::CMD_FLOOR);
  wire w_rate = wr_word & (cmd == ovt_pkg::CMD_RATE);
  wire w_mode = wr_byte & (cmd == ovt_pkg::CMD_MODE);
  wire w_cfg = wr_byte & (cmd == ovt_pkg::CMD_CONFIG);
  wire w_clear = wr_send & (cmd == ovt_pkg::CMD_CLEAR);
  wire w_restore = wr_send & (cmd == ovt_pkg::CMD_RESTORE);
  wire valid_cmd = w_target | w_offset | w_ceil | w_floor | w_rate
    | w_mode | w_cfg | w_clear | w_restore;

  // Configuration fields.
  wire strap_source_select_register = cfg[ovt_pkg::CFG_STRAP];
  wire fault_target_revert_option = cfg[ovt_pkg::CFG_REVERT];
  wire rst_pin_used = cfg[ovt_pkg::CFG_RSTPIN];
  wire [1:0] scale = cfg[ovt_pkg::CFG_SCALE+1:ovt_pkg::CFG_SCALE];

  // Default source, reset pin and fault revert requests.
  wire [15:0] default_src = strap_source_select_register
    ? voltage_select_strap_pin : nvm_target;
  wire load_boot = boot_pending | w_restore;
  wire rpin_rst = rst_pin_used & ~rpin_s;
  wire fault_rev = fault_shutdown & fault_target_revert_option;

  // Status views and read data.
  wire cml_any = cml_data | cml_cmd;
  wire [7:0] sts_byte = {6'h00, cml_any, warn};
  wire [7:0] sts_vout = {4'h0, warn, 3'h0};
  wire [7:0] sts_cml = {cml_cmd, cml_data, 6'h00};
  wire [15:0] rdw =
    (cmd == ovt_pkg::CMD_TARGET) ? output_target_word :
    (cmd == ovt_pkg::CMD_OFFSET) ? output_offset_word :
    (cmd == ovt_pkg::CMD_CEIL) ? output_ceiling_word :
    (cmd == ovt_pkg::CMD_FLOOR) ? floor_word :
    (cmd == ovt_pkg::CMD_RATE) ? rate_word :
    (cmd == ovt_pkg::CMD_MODE) ? {11'h000, mode_exp} :
    (cmd == ovt_pkg::CMD_CONFIG) ? {8'h00, cfg} :
    (cmd == ovt_pkg::CMD_STS_BYTE) ? {8'h00, sts_byte} :
    (cmd == ovt_pkg::CMD_STS_WORD) ? {warn, 7'h00, sts_byte} :
    (cmd == ovt_pkg::CMD_STS_VOUT) ? {8'h00, sts_vout} :
    (cmd == ovt_pkg::CMD_STS_CML) ? {8'h00, sts_cml} : 16'hFFFF;
  wire [7:0] tx_next = tx_hi ? rdw[15:8] : 8'hFF;

  // Effective target in one exponent with limit checks.
  wire [3:0] sh_exp = 4'(mode_exp + ovt_pkg::EXP_BIAS);
  wire [15:0] cand_tgt = w_target ? wdata : output_target_word;
  wire [15:0] cand_ceil = w_ceil ? wdata : output_ceiling_word;
  wire [15:0] cand_floor = w_floor ? wdata : floor_word;
  wire signed [25:0] tgt_c = up(cand_tgt, 1'b0, sh_exp);
  wire signed [25:0] ceil_c = up(cand_ceil, 1'b0, sh_exp);
  wire signed [25:0] floor_c = up(cand_floor, 1'b0, sh_exp);
  wire signed [25:0] range_max = (scale == 2'h0) ? ovt_pkg::RANGE_S0 :
    (scale == 2'h1) ? ovt_pkg::RANGE_S1 :
    (scale == 2'h2) ? ovt_pkg::RANGE_S2 : ovt_pkg::RANGE_S3;
  wire signed [25:0] eff_chk = tgt_c + up(wdata, 1'b1, sh_exp);
  wire trim_bad = (eff_chk < 0) | (eff_chk > range_max);
  wire [15:0] cand_trim = (w_offset & ~trim_bad) ? wdata
    : output_offset_word;
  wire signed [25:0] eff = tgt_c + up(cand_trim, 1'b1, sh_exp);
  wire signed [25:0] floor_lim = (floor_c > ceil_c)
    ? ceil_c : floor_c;
  wire over = eff > ceil_c;
  wire under = eff < floor_lim;
  wire signed [25:0] lim1 = over ? ceil_c : under ? floor_lim : eff;
  wire signed [25:0] lim2 = (lim1 > ovt_pkg::DAC_HW_MAX)
    ? ovt_pkg::DAC_HW_MAX : (lim1 < 0) ? 26'sh0000000 : lim1;
  wire changed = w_target | (w_offset & ~trim_bad) | w_ceil | w_floor;
  wire warn_set = conv_en & changed & (over | under);
  wire bad_mode = w_mode & (conv_en | ($signed(wdata[4:0]) >
    ovt_pkg::EXP_MOST) | ($signed(wdata[4:0]) < ovt_pkg::EXP_LEAST));
  wire cml_data_set = (w_offset & trim_bad) | bad_mode;
  wire cml_cmd_set = commit & ~valid_cmd;
  wire signed [25:0] trim12 = up(output_offset_word, 1'b1, sh_exp);
  wire signed [25:0] save_v = (trim12 > ovt_pkg::SAVE_HI)
    ? ovt_pkg::SAVE_HI : (trim12 < ovt_pkg::SAVE_LO)
    ? ovt_pkg::SAVE_LO : trim12;
  wire [15:0] nvm_trim_cur = 16'($signed({{8{nvm_trim[7]}}, nvm_trim})
    >>> sh_exp);

  // PMBus slave bit engine: receive, acknowledge and transmit.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      st <= ovt_pkg::ST_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      tx_hi <= 1'b0;
      rw <= 1'b0;
      cmd <= 8'h00;
      nbytes <= 2'h0;
      wdata <= 16'h0000;
      wr_live <= 1'b0;
      pmb_sda_oe <= 1'b0;
    end
    else if (ce)
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (start_ev | stop_ev)
      begin
        st <= start_ev ? ovt_pkg::ST_ADDR : ovt_pkg::ST_IDLE;
        bitc <= 4'hF; // The fall closing a start wraps this to zero.
        pmb_sda_oe <= 1'b0;
        wr_live <= 1'b0;
      end
      else if (scl_rise & in_frame & (bitc < 4'h8))
        sh <= {sh[6:0], sda_s};
      else if (scl_rise & is_tx & sda_s)
        st <= ovt_pkg::ST_IDLE;
      else if (scl_fall & in_frame & (bitc == 4'h7))
      begin
        bitc <= 4'h8;
        pmb_sda_oe <= ~is_tx & ~addr_miss;
        rw <= sh[0];
        if (addr_miss)
          st <= ovt_pkg::ST_IDLE;
      end
      else if (scl_fall & in_frame & (bitc == 4'h8))
      begin
        bitc <= 4'h0;
        pmb_sda_oe <= 1'b0;
        case (st)
          ovt_pkg::ST_ADDR:
          begin
            st <= rw ? ovt_pkg::ST_TX : ovt_pkg::ST_CMD;
            pmb_sda_oe <= rw & ~rdw[7];
            tx <= {rdw[6:0], 1'b0};
            tx_hi <= 1'b1;
          end
          ovt_pkg::ST_CMD:
          begin
            cmd <= sh;
            wr_live <= 1'b1;
            nbytes <= 2'h0;
            st <= ovt_pkg::ST_WR;
          end
          ovt_pkg::ST_WR:
          begin
            wdata <= (nbytes == 2'h0) ? {8'h00, sh} : {sh, wdata[7:0]};
            nbytes <= (nbytes == 2'h3) ? nbytes : 2'(nbytes + 2'h1);
          end
          ovt_pkg::ST_TX:
          begin
            pmb_sda_oe <= ~tx_next[7];
            tx <= {tx_next[6:0], 1'b0};
            tx_hi <= 1'b0;
          end
          default: st <= ovt_pkg::ST_IDLE;
        endcase
      end
      else if (scl_fall & in_frame)
      begin
        bitc <= 4'(bitc + 4'h1);
        if (is_tx)
        begin
          pmb_sda_oe <= ~tx[7];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end

  // Target word: boot load, reset pin, fault revert, then host write.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      output_target_word <= 16'h0000;
    else if (ce)
    begin
      if (load_boot)
        output_target_word <= default_src;
      else if (rpin_rst)
        output_target_word <= boot_voltage;
      else if (fault_rev)
        output_target_word <= default_src;
      else if (w_target)
        output_target_word <= wdata;
    end
  end

  // Boot voltage is caught after reset release and on restore only.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      boot_pending <= 1'b1;
      boot_voltage <= 16'h0000;
    end
    else if (ce)
    begin
      boot_pending <= 1'b0;
      if (load_boot)
        boot_voltage <= default_src;
    end
  end

  // Trim, limits, rate, exponent and configuration registers.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      output_offset_word <= ovt_pkg::TRIM_RESET;
      output_ceiling_word <= ovt_pkg::CEIL_RESET;
      floor_word <= ovt_pkg::FLOOR_RESET;
      rate_word <= ovt_pkg::RATE_RESET;
      mode_exp <= ovt_pkg::MODE_RESET;
      cfg <= ovt_pkg::CFG_RESET;
    end
    else if (ce)
    begin
      if (load_boot)
        output_offset_word <= nvm_trim_cur;
      else if (w_offset & ~trim_bad)
        output_offset_word <= wdata;
      if (w_ceil)
        output_ceiling_word <= wdata;
      if (w_floor)
        floor_word <= wdata;
      if (w_rate)
        rate_word <= wdata;
      if (w_mode & ~bad_mode)
        mode_exp <= wdata[4:0];
      if (w_cfg)
        cfg <= wdata[7:0];
    end
  end

  // Sticky status, clamped reference and registered outputs.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      warn <= 1'b0;
      cml_data <= 1'b0;
      cml_cmd <= 1'b0;
      ref_target <= 16'h0000;
      nvm_trim_save <= 8'h00;
      pmb_alert_oe <= 1'b0;
      pmb_alert_out <= 1'b0;
      pmb_sda_out <= 1'b0;
    end
    else if (ce)
    begin
      warn <= warn_set | (warn & ~w_clear);
      cml_data <= cml_data_set | (cml_data & ~w_clear);
      cml_cmd <= cml_cmd_set | (cml_cmd & ~w_clear);
      ref_target <= lim2[15:0];
      nvm_trim_save <= save_v[7:0];
      pmb_alert_oe <= warn_set | cml_data_set | cml_cmd_set
        | ((warn | cml_any) & ~w_clear);
    end
  end

  // Ramps the reference toward the clamped target.
  ovt_slew u_slew (
    .ref_clk(ref_clk),
    .ce(ce),
    .rst(rst),
    .goal(ref_target),
    .period(rate_word),
    .level(dac_code),
    .moving(dac_moving)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_tgt_write;
    ce & w_target & ~load_boot & ~rpin_rst & ~fault_rev
      |=> output_target_word == $past(wdata);
  endproperty
  a_tgt_write: assert property (p_tgt_write)
    else $error("Target write not stored.");

  property p_boot_kept;
    ce & w_target & ~load_boot |=> $stable(boot_voltage);
  endproperty
  a_boot_kept: assert property (p_boot_kept)
    else $error("Boot voltage changed by a target write.");

  property p_boot_src;
    ce & boot_pending |=> boot_voltage == $past(default_src);
  endproperty
  a_boot_src: assert property (p_boot_src)
    else $error("Boot voltage not taken from selected source.");

  property p_pin_rst;
    ce & rpin_rst & ~load_boot |=> output_target_word == boot_voltage;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("Reset pin did not restore boot voltage.");

  property p_ceiling;
    ce |=> $signed({10'h000, ref_target}) <= $past(ceil_c);
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("Reference above ceiling.");

  property p_hw_max;
    $signed({10'h000, ref_target}) <= ovt_pkg::DAC_HW_MAX;
  endproperty
  a_hw_max: assert property (p_hw_max)
    else $error("Reference above hardware maximum.");

  property p_warn_set;
    ce & warn_set |=> warn && pmb_alert_oe;
  endproperty
  a_warn_set: assert property (p_warn_set)
    else $error("Clamp did not raise warning and alert.");

  property p_warn_hold;
    warn & ~(ce & w_clear) |=> warn;
  endproperty
  a_warn_hold: assert property (p_warn_hold)
    else $error("Warning dropped without a clear.");

  property p_trim_rej;
    ce & w_offset & trim_bad & ~load_boot
      |=> $stable(output_offset_word) && cml_data;
  endproperty
  a_trim_rej: assert property (p_trim_rej)
    else $error("Bad trim write accepted.");

  property p_exp_range;
    ($signed(mode_exp) <= ovt_pkg::EXP_MOST)
      && ($signed(mode_exp) >= ovt_pkg::EXP_LEAST);
  endproperty
  a_exp_range: assert property (p_exp_range)
    else $error("Exponent outside supported range.");

  c_tgt_write: cover property (ce & w_target);
  c_clamp: cover property (ce & warn_set);
  c_trim_rej: cover property (ce & w_offset & trim_bad);
  c_read: cover property (ce & is_tx & scl_rise);
endmodule : ovt_target_ctrl

//--- hw/ovt_pkg.sv
package ovt_pkg;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_MODE = 8'h20;
  localparam logic [7:0] CMD_TARGET = 8'h21;
  localparam logic [7:0] CMD_OFFSET = 8'h22;
  localparam logic [7:0] CMD_CEIL = 8'h24;
  localparam logic [7:0] CMD_RATE = 8'h27;
  localparam logic [7:0] CMD_FLOOR = 8'h28;
  localparam logic [7:0] CMD_STS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STS_WORD = 8'h79;
  localparam logic [7:0] CMD_STS_VOUT = 8'h7A;
  localparam logic [7:0] CMD_STS_CML = 8'h7E;
  localparam logic [7:0] CMD_CONFIG = 8'hD0;
  // Device address, value arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h24;
  // Configuration register fields.
  localparam int CFG_STRAP = 0;
  localparam int CFG_REVERT = 1;
  localparam int CFG_RSTPIN = 2;
  localparam int CFG_SCALE = 3;
  // Reset values.
  localparam logic [4:0] MODE_RESET = 5'h17;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] CEIL_RESET = 16'hFFFF;
  localparam logic [15:0] FLOOR_RESET = 16'h0000;
  localparam logic [15:0] RATE_RESET = 16'h0001;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Exponent limits and the bias that turns an exponent into a shift.
  localparam logic signed [4:0] EXP_MOST = 5'sh1C;
  localparam logic signed [4:0] EXP_LEAST = 5'sh14;
  localparam logic [4:0] EXP_BIAS = 5'h0C;
  // Valid ranges per loop scale and hardware maximum, in 2^-12 V units.
  localparam logic signed [25:0] RANGE_S0 = 26'sh0000B33;
  localparam logic signed [25:0] RANGE_S1 = 26'sh0001666;
  localparam logic signed [25:0] RANGE_S2 = 26'sh0002CCC;
  localparam logic signed [25:0] RANGE_S3 = 26'sh0006000;
  localparam logic signed [25:0] DAC_HW_MAX = 26'sh0005800;
  // Trim backup limits at exponent -12.
  localparam logic signed [25:0] SAVE_HI = 26'sh000007F;
  localparam logic signed [25:0] SAVE_LO = 26'sh3FFFF80;
  typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_TX} ovt_bus_e;
endpackage : ovt_pkg

//--- hw/ovt_slew.sv
`timescale 1ns/10ps
module ovt_slew (
  // Clock, enable and reset
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic rst,
  // Goal and cycles per one-step move
  input wire logic [15:0] goal,
  input wire logic [15:0] period,
  // Ramped reference
  output logic [15:0] level,
  output logic moving
);
  logic [15:0] cnt;
  wire tick = (cnt >= period) | (period == 16'h0000);
  wire up_step = goal > level;
  wire dn_step = goal < level;

  // Moves the reference one step toward the goal per rate period.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt <= 16'h0000;
      level <= 16'h0000;
      moving <= 1'b0;
    end
    else if (ce)
    begin
      cnt <= tick ? 16'h0001 : 16'(cnt + 16'h0001);
      moving <= up_step | dn_step;
      if (tick & up_step)
        level <= 16'(level + 16'h0001);
      else if (tick & dn_step)
        level <= 16'(level - 16'h0001);
    end
  end

  property p_slew_step;
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> (level - $past(level) <= 16'h0001)
      || ($past(level) - level <= 16'h0001);
  endproperty
  a_slew_step: assert property (p_slew_step)
    else $error("Reference moved more than one step.");
endmodule : ovt_slew

//--- tb/ovt_host_model.sv
`timescale 1ns/10ps
module ovt_host_model (
  // System clock and resolved data line
  input wire logic ref_clk,
  input wire logic sda_wire,
  // Host side of the bus
  output logic scl,
  output logic sda_low
);
  logic ack_ok;
  // Both lines stand released and high outside frames.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_ok = 1'b1;
  end
  // Waits a number of system clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // One bit of 800 ns; the wire is sampled in the middle of the high phase.
  task automatic put_bit(input logic b, output logic seen);
    sda_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    seen = sda_wire;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : put_bit
  // Data falls while the clock is high, then the clock falls.
  task automatic start();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask : start
  // Data rises while the clock is high, then the bus idles one and a half bit times.
  task automatic stop();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(12);
  endtask : stop
  // Sends a byte MSB first and records whether the device acknowledged.
  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i], s);
    put_bit(1'b1, s);
    ack_ok &= !s;
  endtask : put_byte
  // Receives a byte; last is high to end the read with a not-acknowledge.
  task automatic get_byte(output logic [7:0] v, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, v[i]);
    put_bit(last, s);
  endtask : get_byte
  // Write of n data bytes, low byte first, taking effect on the stop.
  task automatic send(input logic [7:0] cmd, input logic [15:0] d,
    input int n, output logic ok);
    ack_ok = 1'b1;
    start();
    put_byte({ovt_pkg::DEV_ADDR, 1'b0});
    put_byte(cmd);
    for (int i = 0; i < n; i++)
      put_byte(d[8*i +: 8]);
    stop();
    ok = ack_ok;
  endtask : send
  // Word read through a repeated start, low byte then high byte.
  task automatic fetch(input logic [7:0] cmd, output logic [15:0] d);
    start();
    put_byte({ovt_pkg::DEV_ADDR, 1'b0});
    put_byte(cmd);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    start();
    put_byte({ovt_pkg::DEV_ADDR, 1'b1});
    get_byte(d[7:0], 1'b0);
    get_byte(d[15:8], 1'b1);
    stop();
  endtask : fetch
endmodule : ovt_host_model

//--- tb/ovt_target_ctrl_tb_top.sv
`timescale 1ns/10ps
module ovt_target_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic rst;
  logic pin_n;
  logic conv_en;
  logic fault;
  logic scl;
  logic sda_low;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic alert_oe;
  logic alert_out;
  logic [15:0] dac_code;
  logic dac_moving;
  logic [15:0] boot;
  logic [7:0] trim_save;
  int n_fail = 0;
  int comparisons = 0;
  // Pulled-up data line, low whenever either party pulls it.
  assign sda_wire = !sda_low && !(sda_oe && !sda_out);
  // System clock of 100 ns.
  always #50 ref_clk = ~ref_clk;
  ovt_host_model ovt_host_model_i (
    .ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  ovt_target_ctrl ovt_target_ctrl_i (
    .ref_clk(ref_clk), .ce(1'b1), .rst(rst), .pmb_scl(scl),
    .pmb_sda_in(sda_wire), .pmb_sda_out(sda_out), .pmb_sda_oe(sda_oe),
    .pmb_alert_out(alert_out), .pmb_alert_oe(alert_oe),
    .power_good_or_reset_pin(pin_n), .nvm_target(16'h0100),
    .voltage_select_strap_pin(16'h00C0), .nvm_trim(8'h00),
    .conv_en(conv_en), .fault_shutdown(fault), .dac_code(dac_code),
    .dac_moving(dac_moving), .boot_voltage(boot),
    .nvm_trim_save(trim_save));
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask : chk
  // Register write that every byte of must be acknowledged.
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
    input int n);
    logic ok;
    ovt_host_model_i.send(cmd, d, n, ok);
    chk("ack", 16'h0001, 16'(ok));
  endtask : wr
  // Word read compared in full.
  task automatic rdw(input string what, input logic [7:0] cmd,
    input logic [15:0] e);
    logic [15:0] d;
    ovt_host_model_i.fetch(cmd, d);
    chk(what, e, d);
  endtask : rdw
  // Byte read, only the low byte is compared.
  task automatic rdb(input string what, input logic [7:0] cmd,
    input logic [7:0] e);
    logic [15:0] d;
    ovt_host_model_i.fetch(cmd, d);
    chk(what, {8'h00, e}, {8'h00, d[7:0]});
  endtask : rdb
  // Waits, bounded, for the reference to reach a code in 2^-12 V units.
  task automatic wait_dac(input logic [15:0] e);
    for (int i = 0; i < 30000 && dac_code !== e; i++)
      @(posedge ref_clk);
    chk("dac", e, dac_code);
    if (dac_code !== e)
      print_verdict();
  endtask : wait_dac
  // One-cycle fault shutdown event.
  task automatic pulse_fault();
    @(posedge ref_clk);
    fault <= 1'b1;
    @(posedge ref_clk);
    fault <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : pulse_fault
  // Defaults after reset: stored target, boot copy and open ceiling.
  task automatic t_reset();
    rdw("target", ovt_pkg::CMD_TARGET, 16'h0100);
    chk("boot", 16'h0100, boot);
    chk("alert_out", 16'h0000, 16'(alert_out));
    rdw("ceiling", ovt_pkg::CMD_CEIL, ovt_pkg::CEIL_RESET);
    wait_dac(16'h0800);
  endtask : t_reset
  // Target write ramps instead of stepping and leaves the boot word alone.
  task automatic t_target();
    wr(ovt_pkg::CMD_TARGET, 16'h0140, 2);
    chk("moving", 16'h0001, 16'(dac_moving));
    rdw("target", ovt_pkg::CMD_TARGET, 16'h0140);
    wait_dac(16'h0A00);
    chk("boot", 16'h0100, boot);
  endtask : t_target
  // Signed offset, saturated backup and refused out-of-range values.
  task automatic t_trim();
    wr(ovt_pkg::CMD_OFFSET, 16'h0010, 2);
    wait_dac(16'h0A80);
    chk("save", 16'h007F, 16'(trim_save));
    wr(ovt_pkg::CMD_OFFSET, 16'hFFF8, 2);
    wait_dac(16'h09C0);
    chk("save", 16'h00C0, 16'(trim_save));
    wr(ovt_pkg::CMD_OFFSET, 16'h0040, 2);
    rdw("offset", ovt_pkg::CMD_OFFSET, 16'hFFF8);
    rdb("cml", ovt_pkg::CMD_STS_CML, 8'h40);
    chk("alert", 16'h0001, 16'(alert_oe));
    wr(ovt_pkg::CMD_CLEAR, 16'h0000, 0);
    wr(ovt_pkg::CMD_MODE, 16'h0013, 1);
    rdb("cml", ovt_pkg::CMD_STS_CML, 8'h40);
    wr(ovt_pkg::CMD_CLEAR, 16'h0000, 0);
    chk("alert", 16'h0000, 16'(alert_oe));
    wr(ovt_pkg::CMD_OFFSET, 16'h0000, 2);
    wait_dac(16'h0A00);
  endtask : t_trim
  // Over-ceiling target and a ceiling below the target while converting.
  task automatic t_ceiling();
    conv_en <= 1'b1;
    wr(ovt_pkg::CMD_CEIL, 16'h0180, 2);
    wr(ovt_pkg::CMD_TARGET, 16'h0200, 2);
    wait_dac(16'h0C00);
    rdb("vout", ovt_pkg::CMD_STS_VOUT, 8'h08);
    rdb("byte", ovt_pkg::CMD_STS_BYTE, 8'h01);
    rdw("word", ovt_pkg::CMD_STS_WORD, 16'h8001);
    chk("alert", 16'h0001, 16'(alert_oe));
    wr(ovt_pkg::CMD_CLEAR, 16'h0000, 0);
    rdb("vout", ovt_pkg::CMD_STS_VOUT, 8'h00);
    wr(ovt_pkg::CMD_CEIL, 16'h0100, 2);
    wait_dac(16'h0800);
    rdb("vout", ovt_pkg::CMD_STS_VOUT, 8'h08);
    wr(ovt_pkg::CMD_CEIL, 16'hFFFF, 2);
    wr(ovt_pkg::CMD_TARGET, 16'h0140, 2);
    wr(ovt_pkg::CMD_CLEAR, 16'h0000, 0);
    wr(ovt_pkg::CMD_RATE, 16'h0002, 2);
    rdw("rate", ovt_pkg::CMD_RATE, 16'h0002);
    wr(ovt_pkg::CMD_FLOOR, 16'h0180, 2);
    wait_dac(16'h0C00);
    rdb("vout", ovt_pkg::CMD_STS_VOUT, 8'h08);
    wr(ovt_pkg::CMD_FLOOR, 16'h0000, 2);
    wr(ovt_pkg::CMD_RATE, 16'h0001, 2);
    wr(ovt_pkg::CMD_CLEAR, 16'h0000, 0);
    conv_en <= 1'b0;
    wait_dac(16'h0A00);
  endtask : t_ceiling
  // Reset pin, fault revert options and restore from the strap.
  task automatic t_pins();
    wr(ovt_pkg::CMD_CONFIG, 16'h0004, 1);
    @(posedge ref_clk);
    pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rdw("target", ovt_pkg::CMD_TARGET, 16'h0100);
    wait_dac(16'h0800);
    wr(ovt_pkg::CMD_CONFIG, 16'h0002, 1);
    wr(ovt_pkg::CMD_TARGET, 16'h0150, 2);
    pulse_fault();
    rdw("target", ovt_pkg::CMD_TARGET, 16'h0100);
    wr(ovt_pkg::CMD_CONFIG, 16'h0000, 1);
    wr(ovt_pkg::CMD_TARGET, 16'h0150, 2);
    pulse_fault();
    rdw("target", ovt_pkg::CMD_TARGET, 16'h0150);
    wr(ovt_pkg::CMD_CONFIG, 16'h0001, 1);
    wr(ovt_pkg::CMD_RESTORE, 16'h0000, 0);
    rdw("target", ovt_pkg::CMD_TARGET, 16'h00C0);
    chk("boot", 16'h00C0, boot);
  endtask : t_pins
  // Above the hardware maximum but below the ceiling: clamp, no warning.
  task automatic t_hwmax();
    conv_en <= 1'b1;
    wr(ovt_pkg::CMD_TARGET, 16'h0B80, 2);
    wait_dac(16'h5800);
    repeat (16) @(posedge ref_clk);
    chk("dac", 16'h5800, dac_code);
    rdb("vout", ovt_pkg::CMD_STS_VOUT, 8'h00);
    conv_en <= 1'b0;
  endtask : t_hwmax
  // Reset for two cycles, then the scenarios in turn.
  initial
  begin
    rst = 1'b1;
    pin_n = 1'b1;
    conv_en = 1'b0;
    fault = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_target();
    t_trim();
    t_ceiling();
    t_pins();
    t_hwmax();
    print_verdict();
  end
endmodule : ovt_target_ctrl_tb_top
